//--- logic/adc_seq_pkg.sv
// shared constants and carriers for the converter sequencer
package adc_seq_pkg;

	localparam int RESULT_W = 14;
	localparam int BYTE_W   = 8;
	localparam int HI_BITS  = RESULT_W - BYTE_W;
	localparam int FIFO_W   = RESULT_W;
	localparam int FIFO_D   = 16;

	// timing
	localparam int CLK_MHZ      = 100;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TCONV_MAX_NS = 4700;
	// strobe edges arrive three cycles late through sync and edge detect;
	// the count gives those back so eoc meets its limit from the pin
	localparam int SYNC_CYC     = 3;
	localparam int TCONV_CYC    = TCONV_MAX_NS / CLK_PERIOD_NS - SYNC_CYC;
	localparam int TDO_NS       = 20;
	localparam int TDO_CYC_RAW  = (TDO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TDO_CYC      = (TDO_CYC_RAW < 1) ? 1 : TDO_CYC_RAW;
	localparam int CNT_W        = 10;

	// code format: 0 straight binary, 1 offset binary
	localparam logic CODE_STRAIGHT = 1'b0;
	localparam logic CODE_OFFSET   = 1'b1;

	localparam logic [RESULT_W-1:0] OFFSET_FLIP = 14'h2000;
	localparam logic [BYTE_W-1:0]   BUS_IDLE    = 8'h00;
	localparam logic [CNT_W-1:0]    CNT_ZERO    = 10'h000;
	localparam logic [CNT_W-1:0]    CNT_ONE     = 10'h001;

	typedef enum logic [4:0] {
		ST_IDLE    = 5'b00001,
		ST_ACQ     = 5'b00010,
		ST_CONV    = 5'b00100,
		ST_DONE    = 5'b01000,
		ST_READ    = 5'b10000
	} phase_e;

	typedef struct packed {
		logic                    drive;
		logic [BYTE_W-1:0]       data;
	} bus_s;

	typedef struct packed {
		logic ref_on;
		logic powered;
		logic shutdown_sel;
	} power_s;

endpackage

//--- logic/result_fifo.sv
// parameterised valid/ready fifo for conversion results
`timescale 1ns/1ps
module result_fifo #(
	parameter int W = 14,
	parameter int D = 16
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_arst_n,
	// fill side
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	// drain side
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic [W-1:0]      o_out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	assign o_in_ready  = (cnt_q != (AW+1)'(D));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data  = mem[rd_q];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_q] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

//--- logic/adc_seq.sv
// strobe driven power, conversion and byte readout sequencer
`timescale 1ns/1ps
module adc_seq
	import adc_seq_pkg::*;
#(
	parameter logic CODE_FMT = CODE_OFFSET
) (
	// clock and reset
	input  wire logic                         i_clk,
	input  wire logic                         i_arst_n,
	// host pins
	input  wire logic                         i_cs_n,
	input  wire logic                         i_rd_conv_n,
	input  wire logic                         i_upper_byte_select,
	// data pins
	output logic [adc_seq_pkg::BYTE_W-1:0]    o_data,
	output logic [adc_seq_pkg::BYTE_W-1:0]    o_data_oe,
	output logic                              o_eoc_n,
	// sampling core
	output logic                              o_sample_hold,
	input  wire logic [adc_seq_pkg::RESULT_W-1:0] i_raw_code,
	output logic                              o_ref_on,
	output logic                              o_core_on,
	// result stream
	output logic                              o_res_valid,
	input  wire logic                         i_res_ready,
	output logic [adc_seq_pkg::RESULT_W-1:0]  o_res_data,
	output logic                              o_res_overflow
);
	import adc_seq_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] cs_s1_q;
	logic [2:0] cs_s2_q;
	logic       cs_d1_q;
	logic       cs_fall;
	logic       cs_rise;
	logic       rc_hi;
	logic       hbe;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cs_s1_q <= 3'h1;
			cs_s2_q <= 3'h1;
			cs_d1_q <= 1'b1;
		end else begin
			cs_s1_q <= {i_upper_byte_select, i_rd_conv_n, i_cs_n};
			cs_s2_q <= cs_s1_q;
			cs_d1_q <= cs_s2_q[0];
		end
	end

	assign cs_fall = cs_d1_q && !cs_s2_q[0];
	assign cs_rise = !cs_d1_q && cs_s2_q[0];
	assign rc_hi   = cs_s2_q[1];
	assign hbe     = cs_s2_q[2];

	// ----------------------------------------------------------------
	// code formatting
	// ----------------------------------------------------------------
	function automatic logic [RESULT_W-1:0] fmt_code(
		input logic [RESULT_W-1:0] raw,
		input logic                fmt
	);
		fmt_code = (fmt == CODE_OFFSET) ? (raw ^ OFFSET_FLIP) : raw;
	endfunction

	function automatic logic [BYTE_W-1:0] pick_byte(
		input logic [RESULT_W-1:0] res,
		input logic                upper
	);
		pick_byte = upper ? {2'b00, res[RESULT_W-1:BYTE_W]}
		                  : res[BYTE_W-1:0];
	endfunction

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	phase_e              st_q;
	phase_e              st_d;
	power_s              pwr_q;
	power_s              pwr_d;
	logic [CNT_W-1:0]    cnt_q;
	logic [CNT_W-1:0]    cnt_d;
	logic [RESULT_W-1:0] res_q;
	logic [RESULT_W-1:0] res_d;
	logic                eoc_n_q;
	logic                eoc_n_d;
	logic                hold_q;
	logic                hold_d;
	logic                rd_pend_q;
	logic                rd_pend_d;
	logic [CNT_W-1:0]    tdo_q;
	logic [CNT_W-1:0]    tdo_d;
	logic                push;
	logic                fifo_in_ready;
	logic                conv_done;

	assign conv_done = (cnt_q == CNT_ONE);

	always_comb begin
		st_d      = st_q;
		pwr_d     = pwr_q;
		cnt_d     = cnt_q;
		res_d     = res_q;
		eoc_n_d   = eoc_n_q;
		hold_d    = hold_q;
		rd_pend_d = rd_pend_q;
		tdo_d     = tdo_q;
		push      = 1'b0;
		case (st_q)
			ST_IDLE, ST_DONE: begin
				if (cs_fall && !rc_hi) begin
					// start edge wakes and acquires
					st_d          = ST_ACQ;
					pwr_d.powered = 1'b1;
					pwr_d.ref_on  = 1'b1;
					eoc_n_d       = 1'b1;
					hold_d        = 1'b0;
				end else if (cs_fall && rc_hi && st_q == ST_DONE) begin
					st_d      = ST_READ;
					rd_pend_d = 1'b1;
					tdo_d     = CNT_W'(TDO_CYC);
				end
				// rc high start edge in idle leaves state as is
			end
			ST_ACQ: begin
				if (cs_fall) begin
					st_d               = ST_CONV;
					hold_d             = 1'b1;
					pwr_d.shutdown_sel = rc_hi;
					cnt_d              = CNT_W'(TCONV_CYC);
				end
			end
			ST_CONV: begin
				cnt_d = cnt_q - CNT_ONE;
				if (conv_done) begin
					st_d    = ST_DONE;
					eoc_n_d = 1'b0;
					res_d   = fmt_code(i_raw_code, CODE_FMT);
					push    = 1'b1;
					hold_d  = 1'b0;
					cnt_d   = CNT_ZERO;
					if (pwr_q.shutdown_sel) begin
						pwr_d.ref_on  = 1'b0;
						pwr_d.powered = 1'b0;
					end
				end
			end
			ST_READ: begin
				if (tdo_q != CNT_ZERO) begin
					tdo_d = tdo_q - CNT_ONE;
				end
				if (cs_rise) begin
					st_d      = ST_IDLE;
					rd_pend_d = 1'b0;
					tdo_d     = CNT_ZERO;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_q      <= ST_IDLE;
			pwr_q     <= '0;
			cnt_q     <= CNT_ZERO;
			res_q     <= '0;
			eoc_n_q   <= 1'b1;
			hold_q    <= 1'b0;
			rd_pend_q <= 1'b0;
			tdo_q     <= CNT_ZERO;
		end else begin
			st_q      <= st_d;
			pwr_q     <= pwr_d;
			cnt_q     <= cnt_d;
			res_q     <= res_d;
			eoc_n_q   <= eoc_n_d;
			hold_q    <= hold_d;
			rd_pend_q <= rd_pend_d;
			tdo_q     <= tdo_d;
		end
	end

	// ----------------------------------------------------------------
	// data bus
	// ----------------------------------------------------------------
	bus_s bus_d;
	bus_s bus_q;
	logic bus_drive;

	assign bus_drive = (st_q == ST_READ) && rd_pend_q && !cs_rise
	                   && (tdo_q == CNT_ONE || bus_q.drive);
	assign bus_d     = {bus_drive,
	                    bus_drive ? pick_byte(res_q, hbe) : BUS_IDLE};

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bus_q <= '0;
		end else begin
			bus_q <= bus_d;
		end
	end

	// ----------------------------------------------------------------
	// result stream
	// ----------------------------------------------------------------
	logic ovf_q;

	result_fifo #(
		.W (FIFO_W),
		.D (FIFO_D)
	) u_fifo (
		.i_clk       (i_clk),
		.i_arst_n    (i_arst_n),
		.i_in_valid  (push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (res_d),
		.o_out_valid (o_res_valid),
		.i_out_ready (i_res_ready),
		.o_out_data  (o_res_data)
	);

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ovf_q <= 1'b0;
		end else if (push && !fifo_in_ready) begin
			ovf_q <= 1'b1;
		end
	end

	assign o_data         = bus_q.data;
	assign o_data_oe      = {BYTE_W{bus_q.drive}};
	assign o_eoc_n        = eoc_n_q;
	assign o_sample_hold  = hold_q;
	assign o_ref_on       = pwr_q.ref_on;
	assign o_core_on      = pwr_q.powered;
	assign o_res_overflow = ovf_q;

endmodule

//--- bench/adc_seq_assertions.sv
// port checker for the converter sequencer
`timescale 1ns/1ps
module adc_seq_assertions
	import adc_seq_pkg::*;
(
	// clock and reset
	input wire logic                          i_clk,
	input wire logic                          i_arst_n,
	// host pins
	input wire logic                          i_cs_n,
	input wire logic                          i_upper_byte_select,
	// outputs
	input wire logic [adc_seq_pkg::BYTE_W-1:0] o_data,
	input wire logic [adc_seq_pkg::BYTE_W-1:0] o_data_oe,
	input wire logic                          o_eoc_n,
	input wire logic                          o_sample_hold,
	input wire logic                          o_ref_on,
	input wire logic                          o_core_on
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	property p_hiz; o_sample_hold |-> o_data_oe == 8'h00; endproperty
	a_hiz: assert property (p_hiz)
		else $error("bus driven in convert");
	property p_tconv;
		$rose(o_sample_hold) |-> o_eoc_n[*8] ##[1:460] !o_eoc_n;
	endproperty
	a_tconv: assert property (p_tconv)
		else $error("eoc late");
	property p_idle_hiz; o_eoc_n |-> o_data_oe == 8'h00; endproperty
	a_idle_hiz: assert property (p_idle_hiz)
		else $error("bus driven before result");
	property p_whole; o_data_oe == 8'h00 || o_data_oe == 8'hff; endproperty
	a_whole: assert property (p_whole)
		else $error("partial enables");
	property p_top;
		i_upper_byte_select[*4] ##0 o_data_oe[0] |-> o_data[7:6] == 2'b00;
	endproperty
	a_top: assert property (p_top)
		else $error("upper bits set");
	property p_rel;
		$rose(i_cs_n) && o_data_oe[0] |-> ##[1:4] o_data_oe == 8'h00;
	endproperty
	a_rel: assert property (p_rel)
		else $error("bus not released");
	property p_up; $rose(o_core_on) |-> o_ref_on && o_eoc_n; endproperty
	a_up: assert property (p_up)
		else $error("bad power up");
	property p_sd; $fell(o_ref_on) |-> $fell(o_eoc_n); endproperty
	a_sd: assert property (p_sd)
		else $error("reference dropped early");
	property p_hold; $rose(o_sample_hold) |-> $past(o_core_on); endproperty
	a_hold: assert property (p_hold)
		else $error("hold without acquire");
	c_conv: cover property ($rose(o_sample_hold));
	c_read: cover property ($rose(o_data_oe[0]));
	c_sd: cover property ($fell(o_ref_on));
endmodule

bind adc_seq adc_seq_assertions chk_u (
	.i_clk              (i_clk),
	.i_arst_n           (i_arst_n),
	.i_cs_n             (i_cs_n),
	.i_upper_byte_select(i_upper_byte_select),
	.o_data             (o_data),
	.o_data_oe          (o_data_oe),
	.o_eoc_n            (o_eoc_n),
	.o_sample_hold      (o_sample_hold),
	.o_ref_on           (o_ref_on),
	.o_core_on          (o_core_on)
);

//--- bench/host_model.sv
// host processor model driving the strobe pins
`timescale 1ns/1ps
module host_model #(
	parameter int WAKE_CYC = 20
) (
	// clock
	input  wire logic                          i_clk,
	// converter bus
	input  wire logic [adc_seq_pkg::BYTE_W-1:0] i_data,
	input  wire logic [adc_seq_pkg::BYTE_W-1:0] i_data_oe,
	// host pins
	output logic                               o_cs_n,
	output logic                               o_rd_conv_n,
	output logic                               o_upper_byte_select
);
	logic asleep = 1'b0;
	initial begin
		o_cs_n = 1'b1;
		o_rd_conv_n = 1'b0;
		o_upper_byte_select = 1'b0;
	end
	task automatic strobe(input logic rc);
		@(posedge i_clk);
		#1 o_rd_conv_n = rc;
		@(posedge i_clk);
		#1 o_cs_n = 1'b0;
		repeat (2) @(posedge i_clk);
		#1 o_cs_n = 1'b1;
		repeat (6) @(posedge i_clk);
		#1;
	endtask
	task automatic start();
		strobe(1'b0);
		// reference settle time after a wake from shutdown
		if (asleep) begin
			repeat (WAKE_CYC) @(posedge i_clk);
			#1;
		end
		asleep = 1'b0;
	endtask
	task automatic convert(input logic sd);
		strobe(sd);
		asleep = sd;
	endtask
	// x on a byte means the bus was not driven
	task automatic read_bytes(output logic [7:0] lo, output logic [7:0] hi);
		strobe_hold();
		lo = i_data_oe[0] ? i_data : 8'hxx;
		o_upper_byte_select = 1'b1;
		repeat (5) @(posedge i_clk);
		#1 hi = i_data_oe[0] ? i_data : 8'hxx;
		o_cs_n = 1'b1;
		o_upper_byte_select = 1'b0;
		repeat (6) @(posedge i_clk);
		#1;
	endtask
	task automatic strobe_hold();
		@(posedge i_clk);
		#1 o_rd_conv_n = 1'b1;
		@(posedge i_clk);
		#1 o_cs_n = 1'b0;
		repeat (9) @(posedge i_clk);
		#1;
	endtask
endmodule

//--- bench/tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`define CHK(got, exp) \
	num_checks++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("[ERR] %0t got %h exp %h", $time, got, exp); \
	end
module tb;
	import adc_seq_pkg::*;
	// polling starts eight edges after the strobe pin falls
	localparam int EOC_LAST = TCONV_MAX_NS / CLK_PERIOD_NS - 8;
	logic                i_clk = 1'b0;
	logic                i_arst_n = 1'b0;
	logic                cs_n, rc, ubs, eoc_n, hold, ref_on, core_on;
	logic                res_ready = 1'b0;
	logic                res_valid, ovf, res2_valid;
	logic [RESULT_W-1:0] raw = 14'h0000;
	logic [RESULT_W-1:0] res_data, res2_data, e;
	logic [BYTE_W-1:0]   data, oe, lo, hi;
	logic [RESULT_W-1:0] exp_q[$];
	int                  err_total = 0;
	int                  num_checks = 0;
	int                  cyc = 0;
	adc_seq dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(cs_n),
		.i_rd_conv_n(rc), .i_upper_byte_select(ubs), .o_data(data),
		.o_data_oe(oe), .o_eoc_n(eoc_n), .o_sample_hold(hold),
		.i_raw_code(raw), .o_ref_on(ref_on), .o_core_on(core_on),
		.o_res_valid(res_valid), .i_res_ready(res_ready),
		.o_res_data(res_data), .o_res_overflow(ovf));
	host_model host_u (.i_clk(i_clk), .i_data(data), .i_data_oe(oe),
		.o_cs_n(cs_n), .o_rd_conv_n(rc), .o_upper_byte_select(ubs));
	// straight binary twin shares the host pins and the result drain
	adc_seq #(.CODE_FMT(CODE_STRAIGHT)) dut_str_u (.i_clk(i_clk),
		.i_arst_n(i_arst_n), .i_cs_n(cs_n), .i_rd_conv_n(rc),
		.i_upper_byte_select(ubs), .o_data(), .o_data_oe(), .o_eoc_n(),
		.o_sample_hold(), .i_raw_code(raw), .o_ref_on(), .o_core_on(),
		.o_res_valid(res2_valid), .i_res_ready(res_ready),
		.o_res_data(res2_data), .o_res_overflow());
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic conv(input logic [RESULT_W-1:0] code, input logic sd);
		int n;
		n = 0;
		host_u.start();
		`CHK(core_on & ref_on, 1'b1)
		host_u.convert(sd);
		// this conversion's code goes on the input once the sample is held
		raw = code;
		`CHK(hold, 1'b1)
		`CHK(oe, 8'h00)
		while (eoc_n !== 1'b0 && n < 480) begin
			@(posedge i_clk);
			#1 n++;
		end
		`CHK(n <= EOC_LAST, 1'b1)
		`CHK(ref_on, ~sd)
		exp_q.push_back(code);
	endtask
	task automatic rd(input logic [RESULT_W-1:0] r);
		host_u.read_bytes(lo, hi);
		`CHK(lo, r[7:0])
		`CHK(hi, {2'b00, r[13:8]})
		`CHK(oe, 8'h00)
	endtask
	task automatic t_ignore();
		host_u.strobe(1'b1);
		`CHK({core_on, hold}, 2'b00)
		$display("ignore test done");
	endtask
	task automatic t_standby();
		conv(14'h3abc, 1'b0);
		rd(14'h1abc);
		$display("standby test done");
	endtask
	task automatic t_shutdown();
		conv(14'h0155, 1'b1);
		rd(14'h2155);
		$display("shutdown test done");
	endtask
	task automatic t_fill();
		for (int i = 0; i < 14; i++)
			conv(RESULT_W'(i * 291), i[0]);
		`CHK(ovf, 1'b0)
		conv(14'h3fff, 1'b0);
		`CHK(ovf, 1'b1)
		void'(exp_q.pop_back());
		$display("fill test done");
	endtask
	task automatic t_drain();
		res_ready = 1'b1;
		for (int k = 0; k < 40 && exp_q.size() > 0; k++) begin
			if (res_valid === 1'b1) begin
				e = exp_q.pop_front();
				`CHK(res_data, e ^ OFFSET_FLIP)
				`CHK(res2_valid, 1'b1)
				`CHK(res2_data, e)
			end
			@(posedge i_clk);
			#1;
		end
		`CHK({res_valid, 5'(exp_q.size())}, 6'h00)
		$display("drain test done");
	endtask
	initial begin
		repeat (12) @(posedge i_clk);
		#1 i_arst_n = 1'b1;
		t_ignore();
		t_standby();
		t_shutdown();
		t_fill();
		t_drain();
		finish_test();
	end
endmodule
